// file: hw/hot_swap_pkg.sv
// Constants, types and register map of the four-channel hot-swap sequencer
// Function
// - Tracking: all channels on together once lockout, rails, enables and faults allow
// - Tracking: any failed condition turns all off; any enable cycle clears latch
// - Sequencing: each channel follows its enable; any failure turns all off
// - Independent: channel needs lockout, own rail, own enable; fails only itself
// - Independent: fault hits only that channel; own enable cycle clears it
// - Startup interval set by timer resistor, 0.4ms to 50ms, 9ms when floating
// - Startup begins only when conditions hold and channel not latched or retrying
// - During startup slow detector ignored; overcurrent limits rather than trips
// - During startup gate charge current is limited to 100uA
// - During startup, startup trip active holds gate back at twice slow level
// - Good output asserts right when startup ends without fault
// - After startup slow detector active; response 3ms to 100us; code uses a fixed 3ms (SLOW_TICKS)
// - Persistent slow overcurrent: fault, good low, weak 3mA pulldown
// - Fast trip in normal operation: fault, good low, strong 50mA pulldown
// - Retain select floating latches off after fault; tied low gives autoretry
// - Every pass transistor off until a rail exceeds lockout for release delay
// - Autoretry: channel off on fault, restarts after 64 startup intervals
// - All rails below lockout beyond glitch filter restarts lockout delay and startup
`default_nettype none

package hot_swap_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int RES_W = 9;

  localparam int LOCKOUT_DELAY_US = 37500;
  localparam int GLITCH_FILTER_US = 100;
  localparam int START_DEFAULT_US = 9000;
  localparam int START_MIN_US = 400;
  localparam int START_MAX_US = 50000;
  localparam int SLOW_RESP_US = 3000;
  localparam int RETRY_SHIFT = 6;

  localparam logic [CNT_W-1:0] LOCKOUT_TICKS = CNT_W'(LOCKOUT_DELAY_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] GLITCH_TICKS = CNT_W'(GLITCH_FILTER_US * 1000 / TICK_NS);
  localparam logic [RES_W-1:0] START_DEFAULT_TICKS = RES_W'(START_DEFAULT_US * 1000 / TICK_NS);
  localparam logic [RES_W-1:0] START_MIN_TICKS = RES_W'(START_MIN_US * 1000 / TICK_NS);
  localparam logic [RES_W-1:0] START_MAX_TICKS = RES_W'(START_MAX_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] SLOW_TICKS = CNT_W'(SLOW_RESP_US * 1000 / TICK_NS);

  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int CFG_FLOAT_BIT = 0;
  localparam int CFG_RETRY_BIT = 1;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_RES_LSB = 8;
  localparam logic CFG_FLOAT_RST = 1'b1;
  localparam logic CFG_RETRY_RST = 1'b0;
  localparam logic CFG_POL_RST = 1'b0;
  localparam logic [RES_W-1:0] CFG_RES_RST = 9'h05a;
  localparam int ST_GOOD_LSB = 0;
  localparam int ST_FAULT_LSB = 4;
  localparam int ST_GATE_LSB = 8;
  localparam int ST_REL_BIT = 12;
  localparam int ST_MODE_LSB = 13;

  typedef enum logic [1:0] {
    MODE_INDEP = 2'b00,
    MODE_SEQ = 2'b01,
    MODE_TRACK = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    CH_OFF = 3'b000,
    CH_START = 3'b001,
    CH_ON = 3'b010,
    CH_RETRY = 3'b011,
    CH_LATCHED = 3'b100
  } ch_state_t;

endpackage : hot_swap_pkg

`default_nettype wire

// file: hw/lockout_timer.sv
// Supply lockout release delay with glitch filter on the falling side
`default_nettype none

module lockout_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic above_any,
  output logic released
);
  import hot_swap_pkg::*;

  logic [CNT_W-1:0] dly_q, dly_d;
  logic [CNT_W-1:0] gf_q, gf_d;
  logic rel_q, rel_d;

  always_comb begin
    dly_d = dly_q;
    gf_d = gf_q;
    rel_d = rel_q;
    if (above_any) begin
      gf_d = '0;
      if (!rel_q && tick) begin
        if (dly_q == LOCKOUT_TICKS - 16'h0001) begin
          rel_d = 1'b1;
        end else begin
          dly_d = dly_q + 16'h0001;
        end
      end
    end else if (tick) begin
      // Short dips keep the release; only a long dip restarts everything
      if (gf_q >= GLITCH_TICKS) begin
        rel_d = 1'b0;
        dly_d = '0;
      end else begin
        gf_d = gf_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= '0;
      gf_q <= '0;
      rel_q <= 1'b0;
    end else begin
      dly_q <= dly_d;
      gf_q <= gf_d;
      rel_q <= rel_d;
    end
  end

  assign released = rel_q;

endmodule : lockout_timer

`default_nettype wire

// file: hw/quad_hot_swap_sequencer.sv
// Four-channel hot-swap sequencer: modes, startup, fault handling and APB registers
//
// Added by the designer: the register offsets and the APB register port.
`default_nettype none

module quad_hot_swap_sequencer #(
  parameter int NCH = 4,
  parameter int TICK_CYCLES = hot_swap_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hot_swap_pkg::mode_t mode_select,
  input wire logic [NCH-1:0] supply_lockout,
  input wire logic [NCH-1:0] rail_present_level,
  input wire logic [NCH-1:0] enable_threshold,
  input wire logic [NCH-1:0] slow_trip_level,
  input wire logic [NCH-1:0] fast_trip_level,
  output wire logic [NCH-1:0] gate_enable,
  output wire logic [NCH-1:0] gate_charge_limit,
  output wire logic [NCH-1:0] gate_regulate,
  output wire logic [NCH-1:0] pulldown_weak,
  output wire logic [NCH-1:0] pulldown_strong,
  output wire logic [NCH-1:0] good
);
  import hot_swap_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction : addr_hit

  logic tick;
  logic lock_rel;
  logic [NCH-1:0] cond;
  logic [NCH-1:0] clear;
  logic [NCH-1:0] faulted;
  logic [NCH-1:0] on_now;
  logic [NCH-1:0] gate_now;
  logic [RES_W-1:0] start_ticks;
  logic [CNT_W-1:0] retry_ticks;

  tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  lockout_timer u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .above_any(|supply_lockout),
    .released(lock_rel)
  );

  // Configuration and mode registers
  logic float_q, float_d;
  logic retry_q, retry_d;
  logic pol_q, pol_d;
  logic [RES_W-1:0] res_q, res_d;
  logic [31:0] rdata_q, rdata_d;
  mode_t mode_q, mode_d;
  logic taken_q, taken_d;
  logic wr_cfg;
  logic [RES_W-1:0] res_clamped;

  assign wr_cfg = psel && penable && pwrite && addr_hit(paddr, CFG_OFFSET);

  always_comb begin
    float_d = float_q;
    retry_d = retry_q;
    pol_d = pol_q;
    res_d = res_q;
    mode_d = mode_q;
    taken_d = taken_q;
    rdata_d = rdata_q;
    if (wr_cfg) begin
      float_d = pwdata[CFG_FLOAT_BIT];
      retry_d = pwdata[CFG_RETRY_BIT];
      pol_d = pwdata[CFG_POL_BIT];
      res_d = pwdata[CFG_RES_LSB +: RES_W];
    end
    // Mode is caught once at the first release and kept until reset
    if (lock_rel && !taken_q) begin
      mode_d = mode_select;
      taken_d = 1'b1;
    end
    // Read data is captured in the setup cycle so it leaves a flip-flop
    if (psel && !penable) begin
      rdata_d = '0;
      if (addr_hit(paddr, CFG_OFFSET)) begin
        rdata_d[CFG_FLOAT_BIT] = float_q;
        rdata_d[CFG_RETRY_BIT] = retry_q;
        rdata_d[CFG_POL_BIT] = pol_q;
        rdata_d[CFG_RES_LSB +: RES_W] = res_q;
      end else if (addr_hit(paddr, STATUS_OFFSET)) begin
        rdata_d[ST_GOOD_LSB +: NCH] = on_now;
        rdata_d[ST_FAULT_LSB +: NCH] = faulted;
        rdata_d[ST_GATE_LSB +: NCH] = gate_now;
        rdata_d[ST_REL_BIT] = lock_rel;
        rdata_d[ST_MODE_LSB +: 2] = mode_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_q <= CFG_FLOAT_RST;
      retry_q <= CFG_RETRY_RST;
      pol_q <= CFG_POL_RST;
      res_q <= CFG_RES_RST;
      mode_q <= MODE_INDEP;
      taken_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      float_q <= float_d;
      retry_q <= retry_d;
      pol_q <= pol_d;
      res_q <= res_d;
      mode_q <= mode_d;
      taken_q <= taken_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   !(addr_hit(paddr, CFG_OFFSET) || addr_hit(paddr, STATUS_OFFSET));

  // Resistor setting is in kilohm, one tick of 0.1 ms per kilohm
  assign res_clamped = (res_q < START_MIN_TICKS) ? START_MIN_TICKS :
                       (res_q > START_MAX_TICKS) ? START_MAX_TICKS : res_q;
  assign start_ticks = float_q ? START_DEFAULT_TICKS : res_clamped;
  assign retry_ticks = {1'b0, start_ticks, 6'h00};

  // Turn-on conditions per mode
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (mode_q)
        MODE_TRACK: begin
          cond[i] = lock_rel && taken_q && (&rail_present_level) &&
                    (&enable_threshold) && !(|faulted);
          clear[i] = !(&enable_threshold);
        end
        MODE_SEQ: begin
          cond[i] = lock_rel && taken_q && (&rail_present_level) &&
                    enable_threshold[i] && !(|faulted);
          clear[i] = !(&enable_threshold);
        end
        default: begin
          cond[i] = lock_rel && taken_q && rail_present_level[i] &&
                    enable_threshold[i];
          clear[i] = !enable_threshold[i];
        end
      endcase
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    ch_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] slow_q, slow_d;
    logic strong_q, strong_d;
    logic gate_q, lim_q, reg_q, pdw_q, pds_q, good_q;
    logic start_done;
    logic slow_fault;

    assign start_done = tick && (cnt_q == CNT_W'(start_ticks) - 16'h0001);
    assign slow_fault = slow_trip_level[i] && tick && (slow_q == SLOW_TICKS - 16'h0001);

    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      slow_d = slow_q;
      strong_d = strong_q;
      case (st_q)
        CH_OFF: begin
          cnt_d = '0;
          slow_d = '0;
          if (cond[i]) begin
            st_d = CH_START;
          end
        end
        CH_START: begin
          // Slow detector is not looked at here
          slow_d = '0;
          if (!cond[i]) begin
            st_d = CH_OFF;
          end else if (start_done) begin
            st_d = CH_ON;
            cnt_d = '0;
          end else if (tick) begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        CH_ON: begin
          if (slow_trip_level[i]) begin
            slow_d = tick ? slow_q + 16'h0001 : slow_q;
          end else begin
            slow_d = '0;
          end
          if (fast_trip_level[i] || slow_fault) begin
            strong_d = fast_trip_level[i];
            st_d = retry_q ? CH_RETRY : CH_LATCHED;
            cnt_d = '0;
          end else if (!cond[i]) begin
            st_d = CH_OFF;
          end
        end
        CH_RETRY: begin
          if (tick) begin
            if (cnt_q == retry_ticks - 16'h0001) begin
              st_d = CH_OFF;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end
        end
        CH_LATCHED: begin
          // The other party keeps the enable low long enough; any low level clears
          if (clear[i]) begin
            st_d = CH_OFF;
          end
        end
        default: st_d = CH_OFF;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q <= CH_OFF;
        cnt_q <= '0;
        slow_q <= '0;
        strong_q <= 1'b0;
        gate_q <= 1'b0;
        lim_q <= 1'b0;
        reg_q <= 1'b0;
        pdw_q <= 1'b0;
        pds_q <= 1'b0;
        good_q <= 1'b0;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        slow_q <= slow_d;
        strong_q <= strong_d;
        gate_q <= (st_d == CH_START) || (st_d == CH_ON);
        lim_q <= (st_d == CH_START);
        reg_q <= (st_d == CH_START) && fast_trip_level[i];
        pdw_q <= ((st_d == CH_RETRY) || (st_d == CH_LATCHED)) && !strong_d;
        pds_q <= ((st_d == CH_RETRY) || (st_d == CH_LATCHED)) && strong_d;
        good_q <= (st_d == CH_ON) ^ pol_q;
      end
    end

    assign faulted[i] = (st_q == CH_RETRY) || (st_q == CH_LATCHED);
    assign on_now[i] = (st_q == CH_ON);
    assign gate_now[i] = gate_q;
    assign gate_enable[i] = gate_q;
    assign gate_charge_limit[i] = lim_q;
    assign gate_regulate[i] = reg_q;
    assign pulldown_weak[i] = pdw_q;
    assign pulldown_strong[i] = pds_q;
    assign good[i] = good_q;

    sequence s_start_end;
      st_q == CH_START && cond[i] && start_done;
    endsequence

    sequence s_on_fast;
      st_q == CH_ON && fast_trip_level[i];
    endsequence

    a_good_after_start: assert property (s_start_end |=> on_now[i] && good_q != pol_q)
      else $error("good not raised at end of startup");
    a_slow_ignored: assert property (st_q == CH_START && cond[i] |=> !faulted[i])
      else $error("fault taken during startup");
    a_fast_trip: assert property (s_on_fast |=> faulted[i] && pds_q && !gate_q)
      else $error("fast trip did not shut channel with strong pulldown");
    a_latch_mode: assert property (s_on_fast and !retry_q |=> st_q == CH_LATCHED)
      else $error("latched fault handling not taken");
    a_retry_end: assert property (st_q == CH_RETRY && tick &&
                                  cnt_q == retry_ticks - 16'h0001 |=> st_q == CH_OFF)
      else $error("retry delay did not end on time");
    a_indep_drop: assert property (mode_q == MODE_INDEP && on_now[i] &&
                                   !rail_present_level[i] && !fast_trip_level[i] &&
                                   !slow_fault |=> st_q == CH_OFF)
      else $error("independent channel stayed on without its rail");
    a_charge_limit: assert property (reg_q |-> lim_q && gate_q)
      else $error("regulation outside startup");
  end

  a_lock_gate: assert property (!lock_rel |=> ##1 gate_enable == '0)
    else $error("gate on while lockout holds");
  a_track_all: assert property (mode_q == MODE_TRACK |-> gate_enable == '0 ||
                                gate_enable == '1 || (|faulted))
    else $error("tracking channels not switched together");
  a_mode_hold: assert property (taken_q |=> $stable(mode_q))
    else $error("mode changed after sampling");

endmodule : quad_hot_swap_sequencer

`default_nettype wire

// file: hw/tick_gen.sv
// Free-running 0.1 ms time base for all delays of the sequencer
`default_nettype none

module tick_gen #(
  parameter int TICK_CYCLES = hot_swap_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  import hot_swap_pkg::*;

  logic [CNT_W-1:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (div_q == CNT_W'(TICK_CYCLES - 1));
    div_d = tick_d ? '0 : div_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : tick_gen

`default_nettype wire

// file: verif/quad_hot_swap_sequencer_bench.sv
// Self-checking bench of the hot-swap sequencer with a backplane model
`default_nettype none

module quad_hot_swap_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import hot_swap_pkg::*;

  typedef struct {string name; logic [31:0] lo; logic [31:0] hi; logic span;} note_t;
  note_t note_q[$];
  logic [31:0] obs_q[$];
  note_t nt;
  logic [31:0] ob;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;
  mode_t mode_select = MODE_TRACK;
  logic [3:0] vin = 4'h0, en = 4'h0, o_slow = 4'h0, o_fast = 4'h0;
  wire logic [3:0] lock, pres, slow, fast, gate, lim, reg_on, pd_weak, pd_strong, good;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  int num_errors = 0, tests_run = 0, cyc = 0, seed = 32, n, k, m, j;

  always #5 pclk = ~pclk;

  quad_hot_swap_sequencer #(.NCH(4), .TICK_CYCLES(10)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select(mode_select), .supply_lockout(lock), .rail_present_level(pres),
    .enable_threshold(en), .slow_trip_level(slow), .fast_trip_level(fast),
    .gate_enable(gate), .gate_charge_limit(lim), .gate_regulate(reg_on),
    .pulldown_weak(pd_weak), .pulldown_strong(pd_strong), .good(good));

  rail_model far_side (.pclk(pclk), .vin_up(vin), .over_slow(o_slow), .over_fast(o_fast),
    .gate_enable(gate), .supply_lockout(lock), .rail_present_level(pres),
    .slow_trip_level(slow), .fast_trip_level(fast));

  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task note(string s, logic [31:0] lo, logic [31:0] hi, logic sp, logic [31:0] o);
    note_q.push_back('{s, lo, hi, sp});
    obs_q.push_back(o);
  endtask : note

  task chk(string s, logic [31:0] e, logic [31:0] o);
    note(s, e, e, 1'b0, o);
  endtask : chk

  task compare_val(note_t t, logic [31:0] o);
    tests_run++;
    if (o !== t.lo) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", t.name, t.lo, o);
    end
  endtask : compare_val

  task compare_span(note_t t, logic [31:0] o);
    tests_run++;
    if ($isunknown(o) || o < t.lo || o > t.hi) begin
      num_errors++;
      $display("BAD %s expected %0d to %0d seen %0d", t.name, t.lo, t.hi, o);
    end
  endtask : compare_span

  // Results are judged in arrival order, one edge after they were noted
  always @(posedge pclk) begin
    cyc++;
    while (obs_q.size() > 0) begin
      nt = note_q.pop_front();
      ob = obs_q.pop_front();
      if (nt.span) compare_span(nt, ob);
      else compare_val(nt, ob);
    end
    if (cyc == 30000) begin
      num_errors++;
      summarize();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  function automatic logic [3:0] pick(int s);
    case (s)
      0: return gate;
      1: return good;
      2: return pd_weak;
      default: return reg_on;
    endcase
  endfunction : pick

  // Bounded wait for an output vector, sampled away from the clock edge
  task wx(string s, int w, logic [3:0] e, int lim);
    n = 0;
    while (pick(w) !== e && n < lim) begin
      @(negedge pclk);
      n++;
    end
    chk(s, 32'(e), 32'(pick(w)));
  endtask : wx

  task rst(mode_t md, logic [31:0] cfg, logic [3:0] e);
    @(posedge pclk);
    {presetn, vin, en, o_slow, o_fast} <= 17'h0;
    mode_select <= md;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, CFG_OFFSET, cfg);
    @(posedge pclk);
    {vin, en} <= {4'hf, e};
  endtask : rst

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg reset", 32'h00005a01, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, CFG_OFFSET, 32'h400);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg", 32'h400, rd);
    @(posedge pclk);
    {vin, en} <= 8'hff;
    repeat (3600) @(negedge pclk);
    chk("gate in lockout", 32'h0, 32'(gate));
    wx("gate on", 0, 4'hf, 400);
    chk("charge limit", 32'hf, 32'(lim));
    wx("good", 1, 4'hf, 80);
    note("startup", 30, 52, 1'b1, n);
    chk("limit after", 32'h0, 32'(lim));
    apb(1'b1, CFG_OFFSET, 32'h404);
    wx("good inverted", 1, 4'h0, 5);
    apb(1'b1, CFG_OFFSET, 32'h400);
    @(posedge pclk);
    en <= 4'hb;
    wx("all off", 0, 4'h0, 5);
    @(posedge pclk);
    en <= 4'hf;
    wx("all back", 1, 4'hf, 100);
    @(posedge pclk);
    o_fast <= 4'h4;
    wx("track fault", 0, 4'h0, 10);
    chk("strong pull", 32'h4, 32'(pd_strong));
    @(posedge pclk);
    o_fast <= 4'h0;
    repeat (20) @(negedge pclk);
    chk("latched", 32'h0, 32'(gate));
    @(posedge pclk);
    en[0] <= 1'b0;
    repeat (12) @(posedge pclk);
    en[0] <= 1'b1;
    wx("unlatch", 1, 4'hf, 100);
    @(posedge pclk);
    vin <= 4'h0;
    repeat (30) @(posedge pclk);
    vin <= 4'hf;
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("released", 32'h0, 32'(rd[ST_REL_BIT]));
    rst(MODE_INDEP, 32'h400, 4'hf);
    wx("indep on", 1, 4'hf, 4200);
    k = $unsigned($random(seed)) % 4;
    @(posedge pclk);
    mode_select <= MODE_TRACK;
    o_fast <= 4'h1 << k;
    wx("indep fault", 0, ~(4'h1 << k), 10);
    chk("strong one", 32'(4'h1 << k), 32'(pd_strong));
    chk("good one", {28'h0, ~(4'h1 << k)}, 32'(good));
    apb(1'b1, STATUS_OFFSET, $random(seed));
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("mode held", 32'(MODE_INDEP), 32'(rd[14:13]));
    chk("faulted", 32'(4'h1 << k), 32'(rd[7:4]));
    @(posedge pclk);
    o_fast <= 4'h0;
    en[k] <= 1'b0;
    repeat (12) @(posedge pclk);
    en[k] <= 1'b1;
    wx("own restart", 1, 4'hf, 100);
    m = (k + 1) % 4;
    j = (k + 2) % 4;
    @(posedge pclk);
    o_slow <= 4'h1 << m;
    wx("slow fault", 2, 4'h1 << m, 400);
    note("slow delay", 285, 325, 1'b1, n);
    chk("good slow", {28'h0, ~(4'h1 << m)}, 32'(good));
    @(posedge pclk);
    o_slow <= 4'h0;
    vin[j] <= 1'b0;
    wx("rail drop", 0, ~((4'h1 << m) | (4'h1 << j)), 10);
    rst(MODE_SEQ, 32'h402, 4'h3);
    {o_slow, o_fast} <= 8'h12;
    wx("seq on", 0, 4'h3, 4200);
    repeat (4) @(negedge pclk);
    chk("regulate", 32'h2, 32'(reg_on));
    chk("no trip start", 32'h3, 32'(gate));
    @(posedge pclk);
    o_fast <= 4'h0;
    wx("seq good", 1, 4'h3, 80);
    chk("slow ignored", 32'h0, 32'(pd_weak));
    wx("seq all off", 0, 4'h0, 400);
    @(posedge pclk);
    o_slow <= 4'h0;
    wx("retry", 0, 4'h3, 3000);
    note("retry delay", 2500, 2700, 1'b1, n);
    @(posedge pclk);
    en <= 4'h7;
    wx("seq third", 0, 4'h7, 20);
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule : quad_hot_swap_sequencer_bench

`default_nettype wire

// file: verif/rail_model.sv
// Backplane side: supply rails and sense comparators of the four channels
`default_nettype none

module rail_model (
  input wire logic pclk,
  input wire logic [3:0] vin_up,
  input wire logic [3:0] over_slow,
  input wire logic [3:0] over_fast,
  input wire logic [3:0] gate_enable,
  output logic [3:0] supply_lockout,
  output logic [3:0] rail_present_level,
  output logic [3:0] slow_trip_level,
  output logic [3:0] fast_trip_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Load current only flows through a pass transistor that is on
  always @(posedge pclk) begin
    supply_lockout <= vin_up;
    rail_present_level <= vin_up;
    slow_trip_level <= over_slow & gate_enable;
    fast_trip_level <= over_fast & gate_enable;
  end
endmodule : rail_model

`default_nettype wire
